/* src/rsp_pkg.sv */
// shared constants for the receive status packing block
package rsp_pkg;
    // packed receive word
    localparam int PAR_W        = 80;
    localparam int LANE_STEP    = 16;   // lane spacing inside a half
    localparam int HALF_GAP     = 8;    // extra gap before lanes 2 and 3
    localparam int MAX_SYMBOLS  = 4;
    // field positions relative to a lane base
    localparam int POS_DATA     = 0;
    localparam int POS_CTRL     = 8;
    localparam int POS_VIOL     = 9;
    localparam int POS_SYNC     = 10;
    localparam int POS_DERR     = 11;
    localparam int POS_ALIGN    = 12;
    localparam int POS_RMF      = 13;   // two bits, 14:13, lane 0 only
    localparam int POS_RD       = 15;
    // error pair {violation, disparity error}
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_VIOL = 2'h2;
    localparam logic [1:0] ERR_DISP = 2'h3;
    // rate-match fifo state field
    localparam logic [1:0] RMF_NORMAL = 2'h0;
    localparam logic [1:0] RMF_DELETE = 2'h1;
    localparam logic [1:0] RMF_INSERT = 2'h2;
    localparam logic [1:0] RMF_FULL   = 2'h3;
    // register byte addresses
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_STATUS   = 5'h04;
    localparam logic [4:0] REG_IRQ_STAT = 5'h08;
    localparam logic [4:0] REG_IRQ_MASK = 5'h0C;
    localparam logic [4:0] REG_ERR_CNT  = 5'h10;
    // control bits
    localparam int CTRL_SIMPLE    = 0;
    localparam int CTRL_CNT_CLR   = 1;
    // interrupt bits
    localparam int IRQ_VIOL       = 0;
    localparam int IRQ_DERR       = 1;
    localparam int IRQ_SYNC_LOST  = 2;
    localparam int IRQ_RMF        = 3;
    localparam int IRQ_W          = 4;
    // reset values and counter width
    localparam logic       RST_RD_NEG = 1'h1;  // link starts at RD-
    localparam logic [3:0] RST_MASK   = 4'h0;
    localparam logic [3:0] RST_CTRL   = 4'h0;
    localparam int         CNT_W      = 16;
endpackage : rsp_pkg

/* src/rsp_symbol_check.sv */
// one-symbol 8b/10b decode with violation and disparity checking
`timescale 1ns/100ps
module rsp_symbol_check (
    input  wire logic [9:0] code,       // {a,b,c,d,e,i,f,g,h,j}, a at bit 9
    input  wire logic       rd_in_neg,  // running disparity before symbol
    output logic      [7:0] data,
    output logic            ctrl,
    output logic            viol,
    output logic            derr,
    output logic            rd_out_neg
);
    import rsp_pkg::*;

    // six-bit sub-block: {legal, value}
    function automatic logic [5:0] dec6(input logic [5:0] c);
        logic [5:0] r;
        r = 6'h00;
        case (c)
            6'h27, 6'h18: r = 6'h20;
            6'h1D, 6'h22: r = 6'h21;
            6'h2D, 6'h12: r = 6'h22;
            6'h31:        r = 6'h23;
            6'h35, 6'h0A: r = 6'h24;
            6'h29:        r = 6'h25;
            6'h19:        r = 6'h26;
            6'h38, 6'h07: r = 6'h27;
            6'h39, 6'h06: r = 6'h28;
            6'h25:        r = 6'h29;
            6'h15:        r = 6'h2A;
            6'h34:        r = 6'h2B;
            6'h0D:        r = 6'h2C;
            6'h2C:        r = 6'h2D;
            6'h1C:        r = 6'h2E;
            6'h17, 6'h28: r = 6'h2F;
            6'h1B, 6'h24: r = 6'h30;
            6'h23:        r = 6'h31;
            6'h13:        r = 6'h32;
            6'h32:        r = 6'h33;
            6'h0B:        r = 6'h34;
            6'h2A:        r = 6'h35;
            6'h1A:        r = 6'h36;
            6'h3A, 6'h05: r = 6'h37;
            6'h33, 6'h0C: r = 6'h38;
            6'h26:        r = 6'h39;
            6'h16:        r = 6'h3A;
            6'h36, 6'h09: r = 6'h3B;
            6'h0E, 6'h0F, 6'h30: r = 6'h3C;
            6'h2E, 6'h11: r = 6'h3D;
            6'h1E, 6'h21: r = 6'h3E;
            6'h2B, 6'h14: r = 6'h3F;
            default:      r = 6'h00;
        endcase
        return r;
    endfunction

    // four-bit sub-block: {legal, value}
    function automatic logic [3:0] dec4(input logic [3:0] c);
        logic [3:0] r;
        r = 4'h0;
        case (c)
            4'hB, 4'h4:             r = 4'h8;
            4'h9:                   r = 4'h9;
            4'h5:                   r = 4'hA;
            4'hC, 4'h3:             r = 4'hB;
            4'hD, 4'h2:             r = 4'hC;
            4'hA:                   r = 4'hD;
            4'h6:                   r = 4'hE;
            4'hE, 4'h1, 4'h7, 4'h8: r = 4'hF;
            default:                r = 4'h0;
        endcase
        return r;
    endfunction

    function automatic logic [2:0] ones(input logic [5:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < 6; i++) begin
            n = n + 3'(v[i]);
        end
        return n;
    endfunction

    logic [5:0] r6;
    logic [3:0] r4;
    logic [2:0] o6;
    logic [2:0] o4;
    logic       k28;
    logic       rd_mid_neg;
    logic       derr6;
    logic       derr4;

    // decode, then walk disparity through both sub-blocks
    always_comb begin
        k28 = (code[9:4] == 6'h0F) || (code[9:4] == 6'h30);
        r6  = dec6(code[9:4]);
        // RD+ form of K28 (110000) carries the four-bit block inverted
        r4  = dec4((code[9:4] == 6'h30) ? ~code[3:0] : code[3:0]);
        o6  = ones(code[9:4]);
        o4  = ones({2'h0, code[3:0]});
        data = {r4[2:0], r6[4:0]};
        ctrl = k28 || (((r6[4:0] == 5'h17) || (r6[4:0] == 5'h1B) ||
                        (r6[4:0] == 5'h1D) || (r6[4:0] == 5'h1E)) &&
                       ((code[3:0] == 4'h7) || (code[3:0] == 4'h8)));
        viol  = !r6[5] || !r4[3];
        // a heavy block must oppose the running disparity
        derr6 = ((o6 > 3'h3) && !rd_in_neg) ||
                ((o6 < 3'h3) && rd_in_neg);
        rd_mid_neg = (o6 > 3'h3) ? 1'h0 :
                     (o6 < 3'h3) ? 1'h1 : rd_in_neg;
        derr4 = ((o4 > 3'h2) && !rd_mid_neg) ||
                ((o4 < 3'h2) && rd_mid_neg);
        rd_out_neg = (o4 > 3'h2) ? 1'h0 :
                     (o4 < 3'h2) ? 1'h1 : rd_mid_neg;
        derr = derr6 || derr4;
    end

endmodule // rsp_symbol_check

/* src/rsp_status_pack.sv */
// receive 8b/10b status flags and packing into the parallel word
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps

// Behaviour
// - error pair {violation,disparity}: 00 none, 10 violation, 11 disparity error.
// - raise violation flag for any code group outside the 8b/10b tables.
// - raise disparity error flag when a group breaks running-disparity rules.
// - running-disparity flag high for symbol received at negative disparity.
// - alignment flag high when programmed pattern sits in current boundary.
// - sync flag high while synchronization conditions are being met.
// - error and disparity flags on read clock; align and sync need resync.
// - control indicator at bit 8, then 24, then 48 and 64.
// - violation flag at bit 9, then 25, then 49 and 65.
// - disparity error flag at bit 11, then 27, then 51 and 67.
// - running-disparity flag at bit 15, then 31, then 55 and 71.
// - alignment flag at bit 12, then 28, then 52 and 68.
// - sync flag at bit 10, then 26, then 50 and 66.
// - rate-match fifo state field occupies bits 14:13.
// - control indicator is 1 for control characters, 0 for data.
// - fifo state 00 normal, 01 delete, 10 insert, 11 full.
module rsp_status_pack #(
    parameter int SYMBOLS = 4   // 1, 2 or 4 symbols per word
) (
    input  wire logic                       ref_clk,
    input  wire logic                       reset,
    input  wire logic [4:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic [10*SYMBOLS-1:0]      rx_code,
    input  wire logic                       rx_code_valid,
    input  wire logic [SYMBOLS-1:0]         rx_pattern_hit,
    input  wire logic                       rx_sync_ok,
    input  wire logic [1:0]                 rx_rmfifo_state,
    output logic      [rsp_pkg::PAR_W-1:0]  rx_parallel_data,
    output logic                            rx_data_valid,
    output logic      [SYMBOLS-1:0]         rx_datak,
    output logic      [SYMBOLS-1:0]         rx_errdetect,
    output logic      [SYMBOLS-1:0]         rx_disperr,
    output logic      [SYMBOLS-1:0]         rx_runningdisp,
    output logic      [SYMBOLS-1:0]         rx_patterndetect,
    output logic      [SYMBOLS-1:0]         rx_syncstatus,
    output logic      [1:0]                 rx_rmfifostatus,
    output logic                            irq
);
    import rsp_pkg::*;

    // lane base in the packed word: 0, 16, 40, 56
    function automatic int lane_base(input int i);
        return i * LANE_STEP + ((i >= 2) ? HALF_GAP : 0);
    endfunction

    // per-lane decode results, disparity chained lane to lane
    logic [7:0]         lane_data [SYMBOLS];
    logic [SYMBOLS-1:0] lane_ctrl;
    logic [SYMBOLS-1:0] lane_viol;
    logic [SYMBOLS-1:0] lane_derr;
    logic [SYMBOLS:0]   lane_rd_neg;
    logic               rd_neg;

    assign lane_rd_neg[0] = rd_neg;

    for (genvar g = 0; g < SYMBOLS; g++) begin : g_lane
        rsp_symbol_check u_check (
            .code       (rx_code[10*g +: 10]),
            .rd_in_neg  (lane_rd_neg[g]),
            .data       (lane_data[g]),
            .ctrl       (lane_ctrl[g]),
            .viol       (lane_viol[g]),
            .derr       (lane_derr[g]),
            .rd_out_neg (lane_rd_neg[g+1])
        );
    end

    // ---------------- datapath ----------------
    logic [PAR_W-1:0]   next_par;
    logic               next_valid;
    logic [SYMBOLS-1:0] next_k;
    logic [SYMBOLS-1:0] next_err;
    logic [SYMBOLS-1:0] next_derr;
    logic [SYMBOLS-1:0] next_rdf;
    logic [SYMBOLS-1:0] next_pat;
    logic [SYMBOLS-1:0] next_syn;
    logic [1:0]         next_rmf;
    logic               next_rd_neg;
    logic               next_packed;
    logic               word_packed;   // last word carried packed flags
    logic               simple;        // simplified interface selected

    // all flags of a word are built from the same input word
    always_comb begin
        next_par    = rx_parallel_data;
        next_valid  = rx_code_valid;
        next_k      = rx_datak;
        next_err    = rx_errdetect;
        next_derr   = rx_disperr;
        next_rdf    = rx_runningdisp;
        next_pat    = rx_patterndetect;
        next_syn    = rx_syncstatus;
        next_rmf    = rx_rmfifo_state;
        next_rd_neg = rd_neg;
        next_packed = word_packed;
        if (rx_code_valid) begin
            next_par    = '0;
            next_packed = !simple;
            next_rd_neg = lane_rd_neg[SYMBOLS];
            for (int i = 0; i < SYMBOLS; i++) begin
                next_k[i]    = lane_ctrl[i];
                // a violation outranks a disparity error
                next_err[i]  = lane_viol[i] || lane_derr[i];
                next_derr[i] = !lane_viol[i] && lane_derr[i];
                next_rdf[i]  = lane_rd_neg[i];
                next_pat[i]  = rx_pattern_hit[i];
                next_syn[i]  = rx_sync_ok;
                if (simple) begin
                    // flags only on the side ports, bytes packed densely
                    next_par[8*i +: 8] = lane_data[i];
                end else begin
                    next_par[lane_base(i) + POS_DATA +: 8] = lane_data[i];
                    next_par[lane_base(i) + POS_CTRL]  = next_k[i];
                    next_par[lane_base(i) + POS_VIOL]  = next_err[i];
                    next_par[lane_base(i) + POS_DERR]  = next_derr[i];
                    next_par[lane_base(i) + POS_RD]    = next_rdf[i];
                    next_par[lane_base(i) + POS_ALIGN] = next_pat[i];
                    next_par[lane_base(i) + POS_SYNC]  = next_syn[i];
                end
            end
            if (!simple) begin
                next_par[POS_RMF +: 2] = rx_rmfifo_state;
            end
        end
    end

    // flags leave from flops on the read clock, aligned with data
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_parallel_data <= '0;
            rx_data_valid    <= 1'h0;
            rx_datak         <= '0;
            rx_errdetect     <= '0;
            rx_disperr       <= '0;
            rx_runningdisp   <= '0;
            rx_patterndetect <= '0;
            rx_syncstatus    <= '0;
            rx_rmfifostatus  <= RMF_NORMAL;
            rd_neg           <= RST_RD_NEG;
            word_packed      <= 1'h0;
        end else begin
            rx_parallel_data <= next_par;
            rx_data_valid    <= next_valid;
            rx_datak         <= next_k;
            rx_errdetect     <= next_err;
            rx_disperr       <= next_derr;
            rx_runningdisp   <= next_rdf;
            rx_patterndetect <= next_pat;
            rx_syncstatus    <= next_syn;
            rx_rmfifostatus  <= next_rmf;
            rd_neg           <= next_rd_neg;
            word_packed      <= next_packed;
        end
    end

    // ---------------- registers and interrupt ----------------
    logic [3:0]       ctrl_reg;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [CNT_W-1:0] err_cnt;
    logic             sync_q;
    logic [3:0]       next_ctrl;
    logic [IRQ_W-1:0] next_stat;
    logic [IRQ_W-1:0] next_mask;
    logic [CNT_W-1:0] next_cnt;
    logic [IRQ_W-1:0] ev;
    logic [31:0]      next_rdata;
    logic             next_wait;
    logic             wr_go;

    assign simple = ctrl_reg[CTRL_SIMPLE];

    // one wait state: a write lands on the edge where waitrequest is low
    always_comb begin
        wr_go      = avs_write && !avs_waitrequest && avs_byteenable[0];
        next_wait  = !((avs_read || avs_write) && avs_waitrequest);
        next_rdata = avs_readdata;
        if (avs_read && avs_waitrequest) begin
            if (avs_address == REG_CTRL) begin
                next_rdata = {31'h0, ctrl_reg[CTRL_SIMPLE]};
            end else if (avs_address == REG_STATUS) begin
                next_rdata = {28'h0, rx_rmfifo_state, rd_neg, sync_q};
            end else if (avs_address == REG_IRQ_STAT) begin
                next_rdata = {28'h0, irq_stat};
            end else if (avs_address == REG_IRQ_MASK) begin
                next_rdata = {28'h0, irq_mask};
            end else if (avs_address == REG_ERR_CNT) begin
                next_rdata = {16'h0, err_cnt};
            end else begin
                next_rdata = 32'h0;   // unmapped reads as zero
            end
        end
        ev = '0;
        if (rx_code_valid) begin
            ev[IRQ_VIOL] = |lane_viol;
            ev[IRQ_DERR] = |(lane_derr & ~lane_viol);
        end
        ev[IRQ_SYNC_LOST] = sync_q && !rx_sync_ok;
        ev[IRQ_RMF]       = rx_rmfifo_state != RMF_NORMAL;
        next_ctrl = ctrl_reg;
        next_mask = irq_mask;
        next_stat = irq_stat;
        next_cnt  = err_cnt;
        if (wr_go && avs_address == REG_CTRL) begin
            next_ctrl = {3'h0, avs_writedata[CTRL_SIMPLE]};
        end
        if (wr_go && avs_address == REG_IRQ_MASK) begin
            next_mask = avs_writedata[IRQ_W-1:0];
        end
        if (wr_go && avs_address == REG_IRQ_STAT) begin
            next_stat = next_stat & ~avs_writedata[IRQ_W-1:0];
        end
        next_stat = next_stat | ev;   // a new event beats the clear
        // counter saturates so software never sees it wrap
        if (wr_go && avs_address == REG_CTRL &&
            avs_writedata[CTRL_CNT_CLR]) begin
            next_cnt = '0;
        end else if ((ev[IRQ_VIOL] || ev[IRQ_DERR]) && !(&err_cnt)) begin
            next_cnt = err_cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg        <= RST_CTRL;
            irq_stat        <= '0;
            irq_mask        <= RST_MASK;
            err_cnt         <= '0;
            sync_q          <= 1'h0;
            avs_readdata    <= 32'h0;
            avs_waitrequest <= 1'h1;
            irq             <= 1'h0;
        end else begin
            ctrl_reg        <= next_ctrl;
            irq_stat        <= next_stat;
            irq_mask        <= next_mask;
            err_cnt         <= next_cnt;
            sync_q          <= rx_sync_ok;
            avs_readdata    <= next_rdata;
            avs_waitrequest <= next_wait;
            irq             <= |(next_stat & next_mask);
        end
    end

    // ---------------- checks ----------------
    localparam int TOP = lane_base(SYMBOLS - 1);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence bus_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    error_pair_a: assert property (
        (rx_disperr & ~rx_errdetect) == '0)
        else $error("disparity error without violation bit");
    word_align_a: assert property (
        rx_code_valid |=> rx_data_valid && rx_datak == $past(lane_ctrl))
        else $error("status word not aligned with its symbols");
    viol_flag_a: assert property (
        rx_code_valid && lane_viol[0] |=>
            {rx_errdetect[0], rx_disperr[0]} == ERR_VIOL)
        else $error("violation not reported as 10");
    disp_flag_a: assert property (
        rx_code_valid && !lane_viol[0] && lane_derr[0] |=>
            {rx_errdetect[0], rx_disperr[0]} == ERR_DISP)
        else $error("disparity error not reported as 11");
    rd_flag_a: assert property (
        rx_code_valid |=> rx_runningdisp[0] == $past(rd_neg))
        else $error("running disparity flag wrong");
    align_sync_a: assert property (
        rx_code_valid |=> rx_patterndetect == $past(rx_pattern_hit) &&
            rx_syncstatus[0] == $past(rx_sync_ok))
        else $error("align or sync flag wrong");
    pack_ctrl_a: assert property (
        word_packed |-> rx_parallel_data[TOP + POS_CTRL] ==
            rx_datak[SYMBOLS-1])
        else $error("control bit misplaced");
    pack_viol_a: assert property (
        word_packed |-> rx_parallel_data[POS_VIOL] == rx_errdetect[0])
        else $error("violation bit misplaced");
    pack_derr_a: assert property (
        word_packed |-> rx_parallel_data[TOP + POS_DERR] ==
            rx_disperr[SYMBOLS-1])
        else $error("disparity error bit misplaced");
    pack_rd_a: assert property (
        word_packed |-> rx_parallel_data[POS_RD] == rx_runningdisp[0])
        else $error("running disparity bit misplaced");
    pack_align_a: assert property (
        word_packed |-> rx_parallel_data[TOP + POS_ALIGN] ==
            rx_patterndetect[SYMBOLS-1])
        else $error("alignment bit misplaced");
    pack_sync_a: assert property (
        word_packed |-> rx_parallel_data[POS_SYNC] == rx_syncstatus[0])
        else $error("sync bit misplaced");
    pack_rmf_a: assert property (
        rx_code_valid && !simple |=>
            rx_parallel_data[POS_RMF +: 2] == $past(rx_rmfifo_state))
        else $error("fifo state field misplaced");
    bus_wait_a: assert property (bus_req |=> bus_ack)
        else $error("waitrequest handshake broken");
    irq_level_a: assert property (irq == |(irq_stat & irq_mask))
        else $error("interrupt level does not match status");

endmodule // rsp_status_pack

/* bench/rsp_fabric_sync.sv */
// fabric-side consumer that resynchronizes the asynchronous flags
`timescale 1ns/100ps
module rsp_fabric_sync (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [1:0] async_in,
    output logic      [1:0] sync_out
);
    logic [1:0] meta;
    // two stages, since align and sync may change at any moment
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            meta     <= 2'h0;
            sync_out <= 2'h0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // rsp_fabric_sync

/* bench/rsp_status_pack_tb.sv */
// self-checking bench for the receive status packing block
`timescale 1ns/100ps
module rsp_status_pack_tb;
    import rsp_pkg::*;
    logic        ref_clk = 0, reset = 1, rd = 0, wr = 0, cv = 0, sok = 0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic        wait_r, irq, dv;
    logic [39:0] code = 40'h0;
    logic [3:0]  hit = 4'h0, k, ee, de, rdp, pd, ss;
    logic [1:0]  rms = 2'h0, rmo, fab;
    logic [79:0] pw;
    int          miscompares = 0, cmp_count = 0;

    rsp_status_pack u_rsp_status_pack (.ref_clk(ref_clk), .reset(reset),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
        .avs_waitrequest(wait_r), .rx_code(code), .rx_code_valid(cv),
        .rx_pattern_hit(hit), .rx_sync_ok(sok), .rx_rmfifo_state(rms),
        .rx_parallel_data(pw), .rx_data_valid(dv), .rx_datak(k),
        .rx_errdetect(ee), .rx_disperr(de), .rx_runningdisp(rdp),
        .rx_patterndetect(pd), .rx_syncstatus(ss),
        .rx_rmfifostatus(rmo), .irq(irq));
    rsp_fabric_sync u_rsp_fabric_sync (.ref_clk(ref_clk), .reset(reset),
        .async_in({pd[0], ss[0]}), .sync_out(fab));

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    task automatic chk(string n, logic [79:0] e, logic [79:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // one bus access, held until waitrequest is seen low at an edge
    task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
        @(posedge ref_clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge ref_clk); while (wait_r !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // one word in; outputs looked at after the following edge
    task automatic send(logic [39:0] c, logic [3:0] h);
        @(posedge ref_clk);
        cv <= 1'b1;
        code <= c;
        hit <= h;
        @(posedge ref_clk);
        cv <= 1'b0;
        #1;
    endtask
    task automatic rst();
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
    endtask
    // expected error-free word; lanes 2 and 3 sit past the half gap
    function automatic logic [79:0] ew(logic [7:0] d,
            logic [3:0] kk, r, a, s, logic [1:0] m);
        ew = 80'h0;
        for (int i = 0; i < 4; i++) begin
            int b = i * LANE_STEP + (i > 1 ? HALF_GAP : 0);
            ew[b+POS_DATA +: 8] = d;
            ew[b+POS_CTRL] = kk[i];
            ew[b+POS_SYNC] = s[i];
            ew[b+POS_ALIGN] = a[i];
            ew[b+POS_RD] = r[i];
        end
        ew[POS_RMF +: 2] = m;
    endfunction

    // comma characters alternating disparity, then neutral data
    task automatic t_symbols();
        rst();
        sok <= 1'b1;
        send({10'h305, 10'h0FA, 10'h305, 10'h0FA}, 4'h5);
        chk("valid", 1'b1, dv);
        chk("kword", ew(8'hBC, 4'hF, 4'h5, 4'h5, 4'hF, 2'h0), pw);
        chk("kflags", 24'hF0055F, {k, ee, de, rdp, pd, ss});
        repeat (2) @(posedge ref_clk);
        #1;
        chk("fabric", 2'h3, fab);
        send({4{10'h2AA}}, 4'h0);
        chk("dword", ew(8'hB5, 4'h0, 4'hF, 4'h0, 4'hF, 2'h0), pw);
        $display("test symbols done");
    endtask
    // wrong disparity on lane 0, then illegal groups on every lane
    task automatic t_errors();
        send({{3{10'h2AA}}, 10'h305}, 4'h0);
        chk("disp", {ERR_DISP, ERR_DISP},
            {ee[0], de[0], pw[9], pw[11]});
        send(40'h0, 4'h0);
        chk("viol", {4'hF, 4'h0}, {ee, de});
        chk("vbits", 4'hF, {pw[65], pw[49], pw[25], pw[9]});
        chk("vpair", 4'h0, {pw[67], pw[51], pw[27], pw[11]});
        $display("test errors done");
    endtask
    // sticky status, mask, clear, unmapped read
    task automatic t_irq();
        bus(0, REG_IRQ_STAT, 0);
        chk("stat", 32'h3, q);
        chk("irqoff", 1'b0, irq);
        bus(1, REG_IRQ_MASK, 32'h1);
        @(posedge ref_clk);
        #1;
        chk("irqon", 1'b1, irq);
        bus(1, REG_IRQ_STAT, 32'h1);
        bus(0, REG_IRQ_STAT, 0);
        chk("clear", 32'h2, q);
        chk("irqclr", 1'b0, irq);
        bus(0, 5'h14, 0);
        chk("unmap", 32'h0, q);
        $display("test irq done");
    endtask
    // every rate-match fifo code reaches bits 14:13
    task automatic t_rmfifo();
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            rms <= 2'(m);
            send({4{10'h2AA}}, 4'h0);
            chk("rmf", {2'(m), 2'(m)}, {rmo, pw[14:13]});
        end
        $display("test rmfifo done");
    endtask
    // status, error counter and its clear, simplified mode, loss of sync
    task automatic t_regs();
        bus(0, REG_STATUS, 0);
        chk("status", {28'h0, RMF_FULL, 2'h3}, q);
        bus(0, REG_ERR_CNT, 0);
        chk("errcnt", 32'h2, q);
        bus(1, REG_CTRL, 32'h3);
        bus(0, REG_ERR_CNT, 0);
        chk("cntclr", 32'h0, q);
        bus(0, REG_CTRL, 0);
        chk("ctrl", 32'h1, q);
        send({4{10'h2AA}}, 4'h0);
        chk("simple", {48'h0, {4{8'hB5}}}, pw);
        chk("sflags", {12'h0, 4'hF}, {k, ee, de, rdp});
        @(posedge ref_clk);
        sok <= 1'h0;
        bus(0, REG_IRQ_STAT, 0);
        chk("synclost", 32'hE, q);
        $display("test regs done");
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial begin
        t_symbols();
        t_errors();
        t_irq();
        t_rmfifo();
        t_regs();
        summarize();
    end
    // watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        #50000;
        miscompares++;
        summarize();
    end
endmodule // rsp_status_pack_tb
